// file: design/watchdog_timer_control.sv
// Watchdog timer with control register, unlock window and reset request
// ------------------------------------------------------------
// What this block does
// - Count time-out on separate watchdog oscillator
// - Kick restarts counter from zero
// - Expired period raises a one-cycle reset request
// - Select field: 16K cycles doubling to 2048K
// - Enable bit runs or stops watchdog
// - Enable clear ignored unless unlock set
// - Unlock bit self-clears after four cycles
// - Upper three control bits read zero
// ------------------------------------------------------------
`default_nettype none
module watchdog_timer_control
	import wdog_pkg::*;
#(
	parameter int base_log2 = TIMEOUT_BASE_LOG2
)
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic wdog_osc,
	input wire logic kick_instruction,
	input wire logic [IO_ADDR_W-1:0] io_addr,
	input wire logic [DATA_W-1:0] io_wdata,
	input wire logic io_we,
	input wire logic io_re,
	output logic [DATA_W-1:0] io_rdata,
	output logic wdog_reset_req
);
	logic osc_tick;
	logic ctrl_wr;
	logic ctrl_rd;

	logic wdog_enable_ff;
	logic turn_off_unlock_ff;
	logic [SEL_W-1:0] timeout_select_ff;
	logic [UNLOCK_CNT_W-1:0] unlock_cnt_ff;
	logic nxt_wdog_enable;
	logic nxt_turn_off_unlock;
	logic [SEL_W-1:0] nxt_timeout_select;
	logic [UNLOCK_CNT_W-1:0] nxt_unlock_cnt;

	logic [COUNT_W-1:0] count_ff;
	logic reset_req_ff;
	logic [COUNT_W-1:0] nxt_count;
	logic nxt_reset_req;
	logic [SHIFT_W-1:0] shift_amt;
	logic [COUNT_W-1:0] limit_m1;

	logic [DATA_W-1:0] rdata_ff;
	logic [DATA_W-1:0] nxt_rdata;
	logic [DATA_W-1:0] ctrl_view;

	// ------------------------------------------------------------
	// Oscillator edge
	// ------------------------------------------------------------
	// separate oscillator, synchronised
	osc_edge_detect u_osc_edge
	(
		.mclk(mclk),
		.resetn(resetn),
		.ce(ce),
		.osc_in(wdog_osc),
		.rise(osc_tick)
	);

	assign ctrl_wr = io_we && (io_addr == WDOG_CTRL_ADDR);
	assign ctrl_rd = io_re && (io_addr == WDOG_CTRL_ADDR);

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	always_comb
	begin
		nxt_wdog_enable = wdog_enable_ff;
		nxt_turn_off_unlock = turn_off_unlock_ff;
		nxt_timeout_select = timeout_select_ff;
		nxt_unlock_cnt = unlock_cnt_ff;
		if (ce)
		begin
			if (turn_off_unlock_ff)
			begin
				if (unlock_cnt_ff == UNLOCK_CNT_RESET)
				begin
					nxt_turn_off_unlock = 1'b0;
				end
				else
				begin
					nxt_unlock_cnt = unlock_cnt_ff - 3'h1;
				end
			end
			if (ctrl_wr)
			begin
				nxt_timeout_select = io_wdata[SEL_MSB:SEL_LSB];
				if (io_wdata[UNLOCK_BIT])
				begin
					nxt_turn_off_unlock = 1'b1;
					nxt_unlock_cnt = UNLOCK_HOLD_CYCLES - 3'h1;
				end
				if (io_wdata[ENABLE_BIT])
				begin
					nxt_wdog_enable = 1'b1;
				end
				else if (turn_off_unlock_ff)
				begin
					nxt_wdog_enable = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			wdog_enable_ff <= CTRL_RESET[ENABLE_BIT];
			turn_off_unlock_ff <= CTRL_RESET[UNLOCK_BIT];
			timeout_select_ff <= SEL_RESET;
			unlock_cnt_ff <= UNLOCK_CNT_RESET;
		end
		else
		begin
			wdog_enable_ff <= nxt_wdog_enable;
			turn_off_unlock_ff <= nxt_turn_off_unlock;
			timeout_select_ff <= nxt_timeout_select;
			unlock_cnt_ff <= nxt_unlock_cnt;
		end
	end

	// ------------------------------------------------------------
	// Time-out counter
	// ------------------------------------------------------------
	// limit doubles per select step
	assign shift_amt = SHIFT_W'(base_log2) + SHIFT_W'(timeout_select_ff);
	assign limit_m1 = ~({COUNT_W{1'b1}} << shift_amt);

	// Compare with >= so a smaller select never skips past the limit
	always_comb
	begin
		nxt_count = count_ff;
		nxt_reset_req = reset_req_ff;
		if (ce)
		begin
			nxt_reset_req = 1'b0;
			if (!wdog_enable_ff)
			begin
				nxt_count = COUNT_RESET;
			end
			else if (kick_instruction)
			begin
				nxt_count = COUNT_RESET;
			end
			else if (osc_tick)
			begin
				if (count_ff >= limit_m1)
				begin
					nxt_count = COUNT_RESET;
					nxt_reset_req = 1'b1;
				end
				else
				begin
					nxt_count = count_ff + 21'h000001;
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			count_ff <= COUNT_RESET;
			reset_req_ff <= 1'b0;
		end
		else
		begin
			count_ff <= nxt_count;
			reset_req_ff <= nxt_reset_req;
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// reserved bits read zero
	always_comb
	begin
		ctrl_view = READ_IDLE;
		ctrl_view[UNLOCK_BIT] = turn_off_unlock_ff;
		ctrl_view[ENABLE_BIT] = wdog_enable_ff;
		ctrl_view[SEL_MSB:SEL_LSB] = timeout_select_ff;
	end

	always_comb
	begin
		nxt_rdata = rdata_ff;
		if (ce)
		begin
			if (ctrl_rd)
			begin
				nxt_rdata = ctrl_view;
			end
			else
			begin
				nxt_rdata = READ_IDLE;
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			rdata_ff <= READ_IDLE;
		end
		else
		begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign io_rdata = rdata_ff;
	assign wdog_reset_req = reset_req_ff;
endmodule
`default_nettype wire

// file: design/wdog_pkg.sv
// Constants shared by the watchdog control block
`default_nettype none
package wdog_pkg;
	// ------------------------------------------------------------
	// Register access
	// ------------------------------------------------------------
	localparam int IO_ADDR_W = 6;
	localparam int DATA_W = 8;
	localparam logic [IO_ADDR_W-1:0] WDOG_CTRL_ADDR = 6'h21;
	localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
	localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;

	// ------------------------------------------------------------
	// Control field layout
	// ------------------------------------------------------------
	localparam int UNLOCK_BIT = 4;
	localparam int ENABLE_BIT = 3;
	localparam int SEL_MSB = 2;
	localparam int SEL_LSB = 0;
	localparam int SEL_W = 3;
	localparam logic [SEL_W-1:0] SEL_RESET = 3'h0;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int UNLOCK_CNT_W = 3;
	localparam logic [UNLOCK_CNT_W-1:0] UNLOCK_HOLD_CYCLES = 3'h4;
	localparam logic [UNLOCK_CNT_W-1:0] UNLOCK_CNT_RESET = 3'h0;
	// Nominal watchdog oscillator rate, informational
	localparam int WDOG_OSC_FREQ_KHZ = 1000;
	// Shortest time-out is 2**14 = 16K oscillator cycles
	localparam int TIMEOUT_BASE_LOG2 = 14;
	localparam int COUNT_W = 21;
	localparam logic [COUNT_W-1:0] COUNT_RESET = 21'h000000;
	localparam int SHIFT_W = 5;
endpackage
`default_nettype wire

// file: design/osc_edge_detect.sv
// Synchroniser and rising-edge detector for the watchdog oscillator
`default_nettype none
module osc_edge_detect
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic osc_in,
	output logic rise
);
	logic sync1_ff;
	logic sync2_ff;
	logic prev_ff;
	logic rise_ff;
	logic nxt_sync1;
	logic nxt_sync2;
	logic nxt_prev;
	logic nxt_rise;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	// First stage feeds only the second stage
	always_comb
	begin
		nxt_sync1 = sync1_ff;
		nxt_sync2 = sync2_ff;
		nxt_prev = prev_ff;
		nxt_rise = rise_ff;
		if (ce)
		begin
			nxt_sync1 = osc_in;
			nxt_sync2 = sync1_ff;
			nxt_prev = sync2_ff;
			nxt_rise = sync2_ff & ~prev_ff;
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
			prev_ff <= 1'b0;
			rise_ff <= 1'b0;
		end
		else
		begin
			sync1_ff <= nxt_sync1;
			sync2_ff <= nxt_sync2;
			prev_ff <= nxt_prev;
			rise_ff <= nxt_rise;
		end
	end

	assign rise = rise_ff;
endmodule
`default_nettype wire

// file: dv/wdog_props.sv
// Port checker for the watchdog control block
`default_nettype none
module wdog_props
	import wdog_pkg::*;
#(parameter int base_log2 = 2)
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic kick_instruction,
	input wire logic [IO_ADDR_W-1:0] io_addr,
	input wire logic [DATA_W-1:0] io_wdata,
	input wire logic io_we,
	input wire logic io_re,
	input wire logic [DATA_W-1:0] io_rdata,
	input wire logic wdog_reset_req
);
	wire logic hit = io_addr == WDOG_CTRL_ADDR;
	wire logic rd = io_re && !io_we && hit;
	wire logic wr = io_we && hit;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);
	property p_idle;
		!(io_re && hit) |=> io_rdata == READ_IDLE;
	endproperty
	a_idle: assert property (p_idle) else $error("idle data");
	property p_resv;
		rd |=> io_rdata[7:5] == 3'h0;
	endproperty
	a_resv: assert property (p_resv) else $error("reserved");
	property p_sel;
		wr && !io_re ##1 rd |=> io_rdata[2:0] == $past(io_wdata[2:0], 2);
	endproperty
	a_sel: assert property (p_sel) else $error("select");
	property p_unl_on;
		wr && io_wdata[4] ##1 !io_we [*3] ##1 rd |=> io_rdata[4];
	endproperty
	a_unl_on: assert property (p_unl_on) else $error("unlock");
	property p_unl_off;
		wr && io_wdata[4] ##1 !io_we [*4] ##1 rd |=> !io_rdata[4];
	endproperty
	a_unl_off: assert property (p_unl_off) else $error("relock");
	property p_keep;
		rd ##1 io_rdata[4:3] == 2'h1 && wr && !io_wdata[3] ##1 rd
			|=> io_rdata[3];
	endproperty
	a_keep: assert property (p_keep) else $error("enable");
	property p_pulse;
		wdog_reset_req |=> !wdog_reset_req;
	endproperty
	a_pulse: assert property (p_pulse) else $error("pulse");
	property p_kick;
		kick_instruction |=> !wdog_reset_req [*3];
	endproperty
	a_kick: assert property (p_kick) else $error("kick");
endmodule
bind watchdog_timer_control wdog_props #(.base_log2(base_log2)) u_wdog_props
(
	.mclk, .resetn, .kick_instruction, .io_addr, .io_wdata, .io_we, .io_re,
	.io_rdata, .wdog_reset_req
);
`default_nettype wire

// file: dv/cpu_model.sv
// CPU core model driving register accesses and kicks
`default_nettype none
module cpu_model
	import wdog_pkg::*;
(
	input wire logic mclk,
	input wire logic [DATA_W-1:0] io_rdata,
	output logic [IO_ADDR_W-1:0] io_addr,
	output logic [DATA_W-1:0] io_wdata,
	output logic io_we,
	output logic io_re,
	output logic kick_instruction
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		{io_addr, io_wdata, io_we, io_re, kick_instruction} = '0;
	end
	task automatic acc(input logic w, input logic [7:0] d,
		input logic [5:0] a, output logic [7:0] q);
		io_we = w;
		io_re = !w;
		io_addr = a;
		io_wdata = d;
		@(posedge mclk);
		#1;
		q = io_rdata;
	endtask
	// Released lines carry garbage
	task automatic idle;
		io_we = 1'b0;
		io_re = 1'b0;
		io_addr = ~io_addr;
		io_wdata = ~io_wdata;
		@(posedge mclk);
		#1;
	endtask
	task automatic kick;
		kick_instruction = 1'b1;
		@(posedge mclk);
		#1;
		kick_instruction = 1'b0;
	endtask
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench for the watchdog control block
`default_nettype none
module tb_top
	import wdog_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0, resetn = 1'b0, wdog_osc = 1'b0, ce = 1'b1;
	logic [7:0] q;
	int failures = 0, compares = 0, n;
	wire logic [IO_ADDR_W-1:0] io_addr;
	wire logic [DATA_W-1:0] io_wdata, io_rdata;
	wire logic io_we, io_re, kick_instruction, wdog_reset_req;
	always #5 mclk = ~mclk;
	watchdog_timer_control #(.base_log2(2)) u_watchdog_timer_control
	(
		.mclk, .resetn, .ce, .wdog_osc, .kick_instruction, .io_addr,
		.io_wdata, .io_we, .io_re, .io_rdata, .wdog_reset_req
	);
	cpu_model u_cpu_model
	(
		.mclk, .io_rdata, .io_addr, .io_wdata, .io_we, .io_re,
		.kick_instruction
	);
	task automatic chk(string s, logic [7:0] e, logic [7:0] g);
		compares++;
		if (g !== e)
		begin
			failures++;
			$display("unexpected %s: %h, seen %h", s, e, g);
		end
	endtask
	task automatic wr(logic [7:0] d);
		u_cpu_model.acc(1'b1, d, WDOG_CTRL_ADDR, q);
	endtask
	task automatic rd(logic [5:0] a);
		u_cpu_model.acc(1'b0, 8'h00, a, q);
	endtask
	// Bounded: a missing request leaves n at zero
	task automatic rises(int lim);
		n = 0;
		for (int i = 1; i <= lim; i++)
			for (int c = 0; c < 16; c++)
			begin
				wdog_osc = c < 8;
				@(posedge mclk);
				#1;
				if (wdog_reset_req === 1'b1 && n == 0)
					n = i;
			end
	endtask
	task automatic close_out;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic t_reg;
		rd(WDOG_CTRL_ADDR);
		chk("reset", CTRL_RESET, q);
		wr(8'hFF);
		rd(WDOG_CTRL_ADDR);
		chk("ctrl", 8'h1F, q);
		rd(6'h22);
		chk("unmapped", READ_IDLE, q);
		// Low ce must swallow the write and freeze the window
		ce = 1'b0;
		wr(8'h07);
		ce = 1'b1;
		rd(WDOG_CTRL_ADDR);
		chk("frozen", 8'h1F, q);
		$display("reg test ends");
	endtask
	task automatic t_unl;
		wr(8'h18);
		for (int k = 1; k <= 5; k++)
		begin
			rd(WDOG_CTRL_ADDR);
			chk("window", k < 5 ? 8'h18 : 8'h08, q);
		end
		wr(8'h00);
		rd(WDOG_CTRL_ADDR);
		chk("locked", 8'h08, q);
		for (int d = 1; d <= 4; d += 3)
		begin
			wr(8'h18);
			repeat (d - 1) rd(WDOG_CTRL_ADDR);
			wr(8'h00);
			rd(WDOG_CTRL_ADDR);
			// Unlock still stands the cycle after a fast clear
			chk("off", d == 1 ? 8'h10 : 8'h00, q);
			wr(8'h08);
		end
		$display("unlock test ends");
	endtask
	task automatic t_dog;
		u_cpu_model.idle();
		rises(4);
		chk("expiry", 8'h04, 8'(n));
		rises(4);
		chk("restart", 8'h04, 8'(n));
		rises(3);
		u_cpu_model.kick();
		rises(4);
		chk("kick", 8'h04, 8'(n));
		wr(8'h09);
		u_cpu_model.idle();
		u_cpu_model.kick();
		rises(8);
		chk("sel1", 8'h08, 8'(n));
		wr(8'h18);
		wr(8'h00);
		u_cpu_model.idle();
		rises(6);
		chk("stopped", 8'h00, 8'(n));
		$display("timeout test ends");
	endtask
	initial
	begin
		repeat (4) @(posedge mclk);
		#1;
		resetn = 1'b1;
		t_reg();
		t_unl();
		t_dog();
		close_out();
	end
endmodule
`default_nettype wire
